// *** hw/priority_interrupt_arbiter.sv ***
// Purpose: two-level interrupt arbitration with hand-off to the CPU or a transfer channel
// Assumes: peripherals, CPU and transfer channels run on clk_in; no synchronisers needed
// Notes: one request is taken per instr_end_in; entry sequence is push, then enter
// Contract
// - up to 33 nodes, each with one priority setting and enable
// - control byte: flag bit 7, enable bit 6, level 5..2, group 1..0
// - disabled nodes never arbitrate; enabled nodes arbitrate while flagged
// - hardware sets the flag on every source request
// - flag clears on routine entry and on transfer service
// - flag stays set when a transfer brings the channel count to zero
// - software writes to the flag act like hardware sets or clears
// - higher 4-bit level wins first-level arbitration
// - on equal level, higher 2-bit group wins
// - entry pushes old status word, then loads winner level into CPU level
// - nesting up to 15 deep; level 0 never wins
// - levels 15 and 14 use a transfer unless the channel count is zero
// - levels 13 to 1 always take a CPU interrupt
// - enabled level-0 request is never serviced but wakes the CPU
// - channel number is level LSB then group
// - higher channel number ranks above lower on simultaneous transfer requests
// - status word: upper byte interrupt controls and bus hold, lower byte flags
// - at instruction end pick the top request, serve only above CPU level
// - global enable off blocks new requests; started ones finish
// - upper control byte reads zero and ignores writes
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "prio_irq_regs.svh"
module priority_interrupt_arbiter
	import prio_irq_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [`ADDR_W-1:0] addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rd_data_out,
	// peripheral requests, one pulse per request per node
	input wire logic [`NODE_COUNT-1:0] req_in,
	// cpu side
	input wire logic instr_end_in,
	input wire logic cpu_ret_in,
	input wire logic [15:0] psw_ret_in,
	output logic stack_push_out,
	output logic [15:0] stacked_psw_out,
	output logic vector_take_out,
	output logic [`NODE_IDX_W-1:0] vector_num_out,
	output logic [15:0] psw_out,
	output logic wake_out,
	// transfer channels
	input wire logic [7:0] chan_count_zero_in,
	input wire logic xfer_done_in,
	input wire logic xfer_count_zero_in,
	output logic xfer_start_out,
	output logic [2:0] xfer_chan_out
);
	// ranking key: pending, level, group; pending in the top bit keeps idle nodes out
	function automatic logic [6:0] rank_key(input node_ctl_t c);
		rank_key = {c[`CTL_FLAG_BIT] & c[`CTL_ENABLE_BIT], c[`CTL_LVL_HI:`CTL_GRP_LO]};
	endfunction

	function automatic logic [3:0] lvl_of(input node_ctl_t c);
		lvl_of = c[`CTL_LVL_HI:`CTL_LVL_LO];
	endfunction

	node_ctl_t ctl_w [`NODE_COUNT];
	logic [`NODE_COUNT-1:0] pend_w;
	logic [`NODE_COUNT-1:0] clr_w;
	logic [`NODE_COUNT-1:0] node_wr_w;

	seq_state_t st_q, st_d;
	logic [`NODE_IDX_W-1:0] win_idx_q, win_idx_d;
	logic [3:0] win_lvl_q, win_lvl_d;
	logic [1:0] win_grp_q, win_grp_d;
	logic [15:0] psw_q, psw_d;
	logic [15:0] rd_data_q, rd_data_d;
	logic stack_push_q, stack_push_d;
	logic [15:0] stacked_psw_q, stacked_psw_d;
	logic vector_take_q, vector_take_d;
	logic [`NODE_IDX_W-1:0] vector_num_q, vector_num_d;
	logic wake_q, wake_d;
	logic xfer_start_q, xfer_start_d;
	logic [2:0] xfer_chan_q, xfer_chan_d;

	logic [6:0] best_key_w;
	logic [`NODE_IDX_W-1:0] best_idx_w;
	logic take_w;
	logic to_xfer_w;
	logic clr_en_w;

	// one cell per node; shared sources on a node share its byte
	genvar gi;
	generate
		for (gi = 0; gi < `NODE_COUNT; gi++) begin : g_node
			// compare as int so the loop index is never cut to the address width
			assign node_wr_w[gi] = wr_in && (int'(addr_in) == gi);
			assign clr_w[gi] = clr_en_w && (int'(win_idx_q) == gi);
			assign pend_w[gi] = ctl_w[gi][`CTL_FLAG_BIT] && ctl_w[gi][`CTL_ENABLE_BIT];
			source_ctl_cell u_cell (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.req_in(req_in[gi]),
				.svc_clr_in(clr_w[gi]),
				.sw_wr_in(node_wr_w[gi]),
				.sw_data_in(wr_data_in[7:0]),
				.ctl_out(ctl_w[gi])
			);
		end
	endgenerate

	// strict compare keeps the lowest index on a tie; ties are a software fault
	always_comb begin
		best_key_w = 7'h00;
		best_idx_w = '0;
		for (int i = 0; i < `NODE_COUNT; i++) begin
			if (rank_key(ctl_w[i]) > best_key_w) begin
				best_key_w = rank_key(ctl_w[i]);
				best_idx_w = i[`NODE_IDX_W-1:0];
			end
		end
	end

	// level 0 can never exceed the CPU level, so it is never taken
	assign take_w = instr_end_in && best_key_w[6] && psw_q[`SW_GIE_BIT]
		&& (best_key_w[5:2] > psw_q[`SW_LVL_HI:`SW_LVL_LO]);
	assign to_xfer_w = (best_key_w[5:3] == `XFER_LVL_TOP)
		&& !chan_count_zero_in[best_key_w[2:0]];
	assign clr_en_w = (st_q == ST_PUSH) || ((st_q == ST_XFER) && xfer_done_in && !xfer_count_zero_in);

	always_comb begin
		st_d = st_q;
		win_idx_d = win_idx_q;
		win_lvl_d = win_lvl_q;
		win_grp_d = win_grp_q;
		psw_d = psw_q;
		stack_push_d = 1'b0;
		stacked_psw_d = stacked_psw_q;
		vector_take_d = 1'b0;
		vector_num_d = vector_num_q;
		xfer_start_d = 1'b0;
		xfer_chan_d = xfer_chan_q;
		if (wr_in && addr_in == `ADDR_STATUS_WORD) begin
			psw_d = wr_data_in & `SW_WRITE_MASK;
		end
		if (cpu_ret_in) begin
			psw_d = psw_ret_in & `SW_WRITE_MASK;
		end
		unique case (st_q)
			ST_IDLE: begin
				if (take_w) begin
					win_idx_d = best_idx_w;
					win_lvl_d = best_key_w[5:2];
					win_grp_d = best_key_w[1:0];
					if (to_xfer_w) begin
						st_d = ST_XFER;
						xfer_start_d = 1'b1;
						xfer_chan_d = best_key_w[2:0];
					end else begin
						st_d = ST_PUSH;
						stack_push_d = 1'b1;
						stacked_psw_d = psw_q;
					end
				end
			end
			ST_PUSH: begin
				st_d = ST_ENTER;
				psw_d = stacked_psw_q;
				psw_d[`SW_LVL_HI:`SW_LVL_LO] = win_lvl_q;
				vector_take_d = 1'b1;
				vector_num_d = win_idx_q;
			end
			ST_ENTER: begin
				st_d = ST_IDLE;
			end
			ST_XFER: begin
				// a transfer steals cycles only; CPU level is left alone
				if (xfer_done_in) begin
					st_d = ST_IDLE;
				end
			end
		endcase
	end

	// read data stands for one cycle only, zero otherwise
	always_comb begin
		rd_data_d = 16'h0000;
		wake_d = |pend_w;
		if (rd_in) begin
			if (addr_in <= `ADDR_CTL_LAST) begin
				rd_data_d = {8'h00, ctl_w[addr_in[`NODE_IDX_W-1:0]]};
			end else if (addr_in == `ADDR_STATUS_WORD) begin
				rd_data_d = psw_q;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_q <= ST_IDLE;
			win_idx_q <= '0;
			win_lvl_q <= 4'h0;
			win_grp_q <= 2'h0;
			psw_q <= `SW_RESET;
			rd_data_q <= 16'h0000;
			stack_push_q <= 1'b0;
			stacked_psw_q <= 16'h0000;
			vector_take_q <= 1'b0;
			vector_num_q <= '0;
			wake_q <= 1'b0;
			xfer_start_q <= 1'b0;
			xfer_chan_q <= 3'h0;
		end else begin
			st_q <= st_d;
			win_idx_q <= win_idx_d;
			win_lvl_q <= win_lvl_d;
			win_grp_q <= win_grp_d;
			psw_q <= psw_d;
			rd_data_q <= rd_data_d;
			stack_push_q <= stack_push_d;
			stacked_psw_q <= stacked_psw_d;
			vector_take_q <= vector_take_d;
			vector_num_q <= vector_num_d;
			wake_q <= wake_d;
			xfer_start_q <= xfer_start_d;
			xfer_chan_q <= xfer_chan_d;
		end
	end

	assign rd_data_out = rd_data_q;
	assign stack_push_out = stack_push_q;
	assign stacked_psw_out = stacked_psw_q;
	assign vector_take_out = vector_take_q;
	assign vector_num_out = vector_num_q;
	assign psw_out = psw_q;
	assign wake_out = wake_q;
	assign xfer_start_out = xfer_start_q;
	assign xfer_chan_out = xfer_chan_q;

	// helper for the flag checks
	logic [`NODE_COUNT-1:0] req_prev_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			req_prev_q <= '0;
		end else begin
			req_prev_q <= req_in;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	chk_psw_read: assert property (rd_in && addr_in == `ADDR_STATUS_WORD |=> rd_data_out == $past(psw_q))
		else $error("status word read mismatch");
	chk_ctl_upper_zero: assert property (rd_in && addr_in <= `ADDR_CTL_LAST |=> rd_data_out[15:8] == 8'h00)
		else $error("control upper byte not zero");
	chk_push_enter: assert property (stack_push_out |=> vector_take_out && psw_out[15:12] == win_lvl_q)
		else $error("entry did not follow push");
	chk_push_old_psw: assert property (stack_push_out |-> stacked_psw_out == psw_out)
		else $error("pushed status word is not the old one");
	chk_level_raise: assert property (vector_take_out |-> psw_out[15:12] > stacked_psw_out[15:12])
		else $error("entry did not raise cpu level");
	// a request in the push cycle sets the flag again, so that case is left out
	chk_flag_cleared: assert property (vector_take_out && !req_prev_q[vector_num_out]
		|-> !ctl_w[vector_num_out][`CTL_FLAG_BIT])
		else $error("flag not cleared on entry");
	chk_xfer_level: assert property (xfer_start_out |-> win_lvl_q[3:1] == 3'h7)
		else $error("transfer from a low level");
	chk_xfer_chan: assert property (xfer_start_out |-> xfer_chan_out == {win_lvl_q[0], win_grp_q})
		else $error("wrong transfer channel");
	chk_gie_block: assert property (st_q == ST_IDLE && !psw_q[11] |=> !stack_push_out && !xfer_start_out)
		else $error("request taken with global enable off");
	chk_wake_any: assert property (|pend_w |=> wake_out)
		else $error("pending request did not wake cpu");
	// every node is watched, so the check fires whichever source the bench uses
	generate
		for (gi = 0; gi < `NODE_COUNT; gi++) begin : g_set_chk
			chk_set_wins: assert property (req_in[gi] |=> ctl_w[gi][`CTL_FLAG_BIT])
				else $error("request flag not set");
		end
	endgenerate
	chk_count_zero_keep: assert property (st_q == ST_XFER && xfer_done_in && xfer_count_zero_in && !req_in[win_idx_q]
		&& !node_wr_w[win_idx_q] |=> ctl_w[win_idx_q][7] == $past(ctl_w[win_idx_q][7]))
		else $error("flag lost at count zero");
	// levels below the transfer pair go to the CPU whatever the channel counts say
	chk_low_to_cpu: assert property (st_q == ST_IDLE && take_w
		&& best_key_w[5:3] != `XFER_LVL_TOP |=> stack_push_out && !xfer_start_out)
		else $error("low level request not sent to cpu");
	chk_zero_to_cpu: assert property (st_q == ST_IDLE && take_w
		&& chan_count_zero_in[best_key_w[2:0]] |=> stack_push_out && !xfer_start_out)
		else $error("empty channel did not fall back to cpu");
	chk_psw_gap_zero: assert property (psw_out[9:7] == 3'h0)
		else $error("status word reserved bits set");
	chk_entry_not_lvl0: assert property (vector_take_out |-> psw_out[15:12] != 4'h0)
		else $error("level 0 request entered");

	cov_cpu_entry: cover property (stack_push_out ##1 vector_take_out);
	cov_xfer_done: cover property (xfer_start_out ##[1:20] xfer_done_in);
	cov_xfer_last: cover property (st_q == ST_XFER && xfer_done_in && xfer_count_zero_in);
	cov_zero_cpu: cover property (st_q == ST_IDLE && take_w && !to_xfer_w && best_key_w[5:3] == `XFER_LVL_TOP);
	cov_lvl0_wake: cover property (wake_out && st_q == ST_IDLE && !take_w);
endmodule // priority_interrupt_arbiter
`default_nettype wire

// *** hw/prio_irq_regs.svh ***
// Purpose: offsets, field positions, reset values and counts of the interrupt arbiter
// Assumes: register port addressed by word index
// Notes: definitions only
`ifndef PRIO_IRQ_REGS_SVH
`define PRIO_IRQ_REGS_SVH

`define NODE_COUNT 33
`define NODE_IDX_W 6
`define ADDR_W 7
`define ADDR_CTL_LAST 7'h20
`define ADDR_STATUS_WORD 7'h40
`define CTL_FLAG_BIT 7
`define CTL_ENABLE_BIT 6
`define CTL_LVL_HI 5
`define CTL_LVL_LO 2
`define CTL_GRP_HI 1
`define CTL_GRP_LO 0
`define CTL_RESET 8'h00
`define SW_LVL_HI 15
`define SW_LVL_LO 12
`define SW_GIE_BIT 11
`define SW_HOLD_BIT 10
`define SW_WRITE_MASK 16'hFC7F
`define SW_RESET 16'h0000
`define XFER_LVL_TOP 3'h7

`endif

// *** hw/prio_irq_pkg.sv ***
// Purpose: types shared by the interrupt arbiter files
// Assumes: nothing
// Notes: constants live in prio_irq_regs.svh
package prio_irq_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PUSH = 2'b01,
		ST_ENTER = 2'b10,
		ST_XFER = 2'b11
	} seq_state_t;
	typedef logic [7:0] node_ctl_t;
endpackage

// *** hw/source_ctl_cell.sv ***
// Purpose: one node's source_interrupt_control byte
// Assumes: request and clear pulses come from the same clock
// Notes: a hardware request wins over a software write and a service clear
`timescale 1ns/1ps
`default_nettype none
`include "prio_irq_regs.svh"
module source_ctl_cell
	import prio_irq_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// events
	input wire logic req_in,
	input wire logic svc_clr_in,
	// software write
	input wire logic sw_wr_in,
	input wire logic [7:0] sw_data_in,
	// stored control byte
	output node_ctl_t ctl_out
);
	node_ctl_t ctl_q;
	node_ctl_t ctl_d;

	always_comb begin
		ctl_d = ctl_q;
		if (sw_wr_in) begin
			ctl_d = sw_data_in;
		end else if (svc_clr_in) begin
			ctl_d[`CTL_FLAG_BIT] = 1'b0;
		end
		if (req_in) begin
			ctl_d[`CTL_FLAG_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctl_q <= `CTL_RESET;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	assign ctl_out = ctl_q;
endmodule // source_ctl_cell
`default_nettype wire

// *** verif/cpu_chan_model.sv ***
// Purpose: stand-in for the CPU pipeline and the transfer channels
// Assumes: one clock, synchronous reset
// Notes: instruction end every 4 cycles; a transfer ends 3 cycles after its start
`timescale 1ns/1ps
`default_nettype none
module cpu_chan_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// from the arbiter
	input wire logic xfer_start_in,
	// bench control
	input wire logic zero_cfg_in,
	// to the arbiter
	output logic instr_end_out,
	output logic xfer_done_out,
	output logic xfer_count_zero_out
);
	logic [1:0] ph_q;
	logic [2:0] xf_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ph_q <= 2'h0;
			xf_q <= 3'h0;
		end else begin
			ph_q <= ph_q + 2'h1;
			xf_q <= xfer_start_in ? 3'h3 : ((xf_q != 3'h0) ? xf_q - 3'h1 : 3'h0);
		end
	end
	// fixed pace only; uneven instruction lengths are not exercised
	assign instr_end_out = rst_n_in && (ph_q == 2'h3);
	assign xfer_done_out = (xf_q == 3'h1);
	// count-zero is only qualified beside done, so show the wrong level elsewhere
	assign xfer_count_zero_out = xfer_done_out ? zero_cfg_in : ~zero_cfg_in;
endmodule // cpu_chan_model
`default_nettype wire

// *** verif/priority_interrupt_arbiter_tb.sv ***
// Purpose: self-checking bench for the interrupt arbiter
// Assumes: register port answers reads one cycle later
// Notes: outputs sampled on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "prio_irq_regs.svh"
module priority_interrupt_arbiter_tb;
	import prio_irq_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [`ADDR_W-1:0] addr_in = '0;
	logic [15:0] wr_data_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [`NODE_COUNT-1:0] req_in = '0;
	logic cpu_ret_in = 1'b0;
	logic [15:0] psw_ret_in = 16'h0000;
	logic [7:0] chan_count_zero_in = 8'h00;
	logic zero_cfg = 1'b0;
	logic instr_end, xfer_done, xfer_cz, push, take, wake, xstart;
	logic [15:0] rd_data, stacked, processor_status_word;
	logic [5:0] vnum;
	logic [2:0] xchan;
	int miscompares = 0;
	int tests_run = 0;
	always #25 clk_in = ~clk_in;
	priority_interrupt_arbiter i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data), .req_in(req_in),
		.instr_end_in(instr_end), .cpu_ret_in(cpu_ret_in), .psw_ret_in(psw_ret_in), .stack_push_out(push),
		.stacked_psw_out(stacked), .vector_take_out(take), .vector_num_out(vnum), .psw_out(processor_status_word),
		.wake_out(wake), .chan_count_zero_in(chan_count_zero_in), .xfer_done_in(xfer_done),
		.xfer_count_zero_in(xfer_cz), .xfer_start_out(xstart), .xfer_chan_out(xchan));
	cpu_chan_model i_far (.clk_in(clk_in), .rst_n_in(rst_n_in), .xfer_start_in(xstart),
		.zero_cfg_in(zero_cfg), .instr_end_out(instr_end), .xfer_done_out(xfer_done),
		.xfer_count_zero_out(xfer_cz));
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (e !== g) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [6:0] a, logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(logic [6:0] a, logic [15:0] e, string n);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		chk(n, e, rd_data);
	endtask
	task automatic pulse(int n);
		@(posedge clk_in);
		req_in[n] <= 1'b1;
		@(posedge clk_in);
		req_in <= '0;
	endtask
	task automatic ret();
		@(posedge clk_in);
		psw_ret_in <= 16'h0800;
		cpu_ret_in <= 1'b1;
		@(posedge clk_in);
		cpu_ret_in <= 1'b0;
	endtask
	// x selects transfer start instead of routine entry
	task automatic wait_ev(bit x, output bit s);
		bit p;
		s = 1'b0;
		p = 1'b0;
		repeat (20) begin
			@(negedge clk_in);
			if ((x ? xstart : take) === 1'b1) begin
				s = 1'b1;
				if (!x)
					chk("push before entry", 16'h0001, p);
				break;
			end
			p = push;
		end
	endtask
	task automatic t_regs();
		rd(7'h00, 16'h0000, "node reset");
		wr(7'h03, 16'hFFD7);
		rd(7'h03, 16'h00D7, "node byte");
		wr(7'h03, 16'h0000);
		rd(7'h30, 16'h0000, "unmapped");
		wr(7'h40, 16'hFFFF);
		rd(7'h40, 16'hFC7F, "status word");
		wr(7'h40, 16'h0800);
	endtask
	task automatic t_xfer();
		bit s;
		wr(7'h04, 16'h007E);
		pulse(4);
		wait_ev(1'b1, s);
		chk("xfer start", 16'h0001, s);
		chk("xfer chan", 16'h0006, xchan);
		repeat (12) @(negedge clk_in);
		rd(7'h04, 16'h007E, "flag after xfer");
		chk("psw kept", 16'h0800, processor_status_word);
		@(posedge clk_in);
		zero_cfg <= 1'b1;
		pulse(4);
		wait_ev(1'b1, s);
		chk("second xfer", 16'h0001, s);
		@(posedge clk_in);
		chan_count_zero_in <= 8'h40;
		wait_ev(1'b0, s);
		chk("count zero vector", 16'h0004, vnum);
		chk("level 15", 16'hF800, processor_status_word);
		ret();
		zero_cfg <= 1'b0;
		chan_count_zero_in <= 8'h00;
		wr(7'h04, 16'h0000);
	endtask
	task automatic t_arb();
		bit s;
		wr(7'h40, 16'h0000);
		wr(7'h01, 16'h0055);
		wr(7'h02, 16'h0056);
		wr(7'h08, 16'h00A4);
		wr(7'h09, 16'h0048);
		pulse(1);
		pulse(2);
		pulse(9);
		wait_ev(1'b0, s);
		chk("enable off", 16'h0000, s);
		wr(7'h40, 16'h0800);
		wait_ev(1'b0, s);
		chk("group win", 16'h0002, vnum);
		chk("entry psw", 16'h5800, processor_status_word);
		chk("stacked", 16'h0800, stacked);
		rd(7'h02, 16'h0056, "flag at entry");
		wait_ev(1'b0, s);
		chk("same level", 16'h0000, s);
		ret();
		wait_ev(1'b0, s);
		chk("next group", 16'h0001, vnum);
		ret();
		wait_ev(1'b0, s);
		chk("low level", 16'h0009, vnum);
		chk("low psw", 16'h2800, processor_status_word);
		ret();
		wr(7'h08, 16'h0000);
	endtask
	task automatic t_lvl0();
		bit s;
		wr(7'h05, 16'h0040);
		@(negedge clk_in);
		chk("wake idle", 16'h0000, wake);
		pulse(5);
		repeat (2) @(negedge clk_in);
		chk("wake", 16'h0001, wake);
		wait_ev(1'b0, s);
		chk("level 0 idle", 16'h0000, s);
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(negedge clk_in);
		chk("psw reset", 16'h0000, processor_status_word);
		t_regs();
		t_xfer();
		t_arb();
		t_lvl0();
		end_sim();
	end
	// the sequence needs well under 1000 cycles; allow four times that
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule // priority_interrupt_arbiter_tb
`default_nettype wire
